/* rtl/rss_sequencer.v */
// Implementation choices: the Avalon-MM slave port and the address map.
`timescale 1ns/10ps
`include "rss_map.vh"
module rss_sequencer #(
    parameter [16:0] POWERUP_TIMER_TICKS = 17'd64000,
    parameter [10:0] OST_CYCLES = 11'd1024
) (
    input  wire        CLK,
    input  wire        RESET,
    input  wire        SUPPLY_ABOVE_POR,
    input  wire        SUPPLY_ABOVE_BOR,
    input  wire        OVERTEMP,
    input  wire        EXT_RESET_PIN_IN,
    output wire        EXT_RESET_PIN_OUT,
    output wire        EXT_RESET_PIN_OE_N,
    output wire        EXT_RESET_PULLUP_EN,
    input  wire        WATCHDOG_TIMEOUT,
    input  wire        WATCHDOG_CLEAR,
    input  wire        SLEEP_ENTER,
    input  wire        WAKE_EVENT,
    input  wire        CFG_BROWNOUT_ENABLE,
    input  wire        CFG_EXT_RESET_PIN_ENABLE,
    input  wire        CFG_POWERUP_TIMER_DISABLE_N,
    output wire        REG_RESET,
    output wire        FETCH_ENABLE,
    output wire        WAKE_RESUME,
    output wire [4:0]  TRIM_VALUE,
    input  wire [7:0]  AVS_ADDRESS,
    input  wire        AVS_READ,
    input  wire        AVS_WRITE,
    input  wire [3:0]  AVS_BYTEENABLE,
    input  wire [31:0] AVS_WRITEDATA,
    output wire [31:0] AVS_READDATA,
    output wire        AVS_WAITREQUEST
);

    function integer cyc_up;
        input integer ns;
        begin
            cyc_up = (ns * `RSS_CLK_MHZ + 999) / 1000;
            if (cyc_up < 1) begin
                cyc_up = 1;
            end
        end
    endfunction

    localparam integer BOR_I     = cyc_up(`RSS_T_BOR_NS);
    localparam integer BIAS_I    = cyc_up(`RSS_T_BIAS_NS);
    localparam integer FILT_I    = cyc_up(`RSS_T_PIN_FILT_NS);
    localparam integer RC_I      = cyc_up(`RSS_T_RC_TICK_NS);
    localparam [11:0] BOR_CYC    = BOR_I[11:0];
    localparam [11:0] BIAS_CYC   = BIAS_I[11:0];
    localparam [11:0] FILT_CYC   = FILT_I[11:0];
    localparam [4:0]  RC_DIV     = RC_I[4:0];
    localparam [3:0]  TRIM_SETTLE = `RSS_TRIM_SETTLE_PER;

    localparam [2:0] S_HOLD    = 3'h0;
    localparam [2:0] S_POWERUP_TIMER    = 3'h1;
    localparam [2:0] S_OST     = 3'h2;
    localparam [2:0] S_BIAS    = 3'h3;
    localparam [2:0] S_PINWAIT = 3'h4;
    localparam [2:0] S_RUN     = 3'h5;
    localparam [2:0] S_SLEEP   = 3'h6;

    reg  [2:0]  state_q;
    reg  [2:0]  state_d;
    reg  [2:0]  cause_d;
    reg  [2:0]  cause_q;
    reg         pend_powerup_timer_q;
    reg         pend_ost_q;
    reg         from_reset_q;
    reg  [11:0] bor_cnt_q;
    reg         bor_hit_q;
    reg  [11:0] pin_cnt_q;
    reg         pin_low_q;
    reg  [4:0]  rc_div_q;
    reg         rc_tick_q;
    reg  [16:0] powerup_timer_cnt_q;
    reg  [11:0] seq_cnt_q;
    reg         por_flag_n_q;
    reg         bor_flag_n_q;
    reg         timeout_flag_q;
    reg         powerdown_flag_q;
    reg  [4:0]  trim_target_q;
    reg  [4:0]  trim_applied_q;
    reg  [3:0]  trim_cnt_q;
    reg         reg_reset_q;
    reg         fetch_en_q;
    reg         wake_resume_q;
    reg         pullup_q;
    reg         waitreq_q;
    reg  [31:0] rdata_q;
    reg  [31:0] rdata_d;

    wire por_cond  = !SUPPLY_ABOVE_POR;                                    // [RULE_21]
    wire asleep    = (state_q == S_SLEEP);
    wire pin_armed = CFG_EXT_RESET_PIN_ENABLE;                             // [RULE_09]
    wire powerup_timer_on   = !CFG_POWERUP_TIMER_DISABLE_N;                         // [RULE_15]
    wire hold_cond = por_cond || OVERTEMP || !SUPPLY_ABOVE_BOR;            // [RULE_11]
    wire bus_wr    = AVS_WRITE && !waitreq_q && AVS_BYTEENABLE[0];
    wire seq_done  = (seq_cnt_q == 12'h001);

    // Brown-out qualifier; disabled while asleep so only power-on applies
    always @(posedge CLK) begin
        if (RESET || !CFG_BROWNOUT_ENABLE || asleep || SUPPLY_ABOVE_BOR) begin  // [RULE_14]
            bor_cnt_q <= 12'h000;
            bor_hit_q <= 1'b0;
        end else if (bor_cnt_q >= BOR_CYC - 12'h001) begin
            bor_hit_q <= 1'b1;                                             // [RULE_10]
        end else begin
            bor_cnt_q <= bor_cnt_q + 12'h001;
        end
    end

    // Pin filter: low must persist; release is taken at once
    always @(posedge CLK) begin
        if (RESET || !pin_armed || EXT_RESET_PIN_IN) begin
            pin_cnt_q <= 12'h000;
            pin_low_q <= 1'b0;
        end else if (pin_cnt_q >= FILT_CYC - 12'h001) begin
            pin_low_q <= 1'b1;                                             // [RULE_07]
        end else begin
            pin_cnt_q <= pin_cnt_q + 12'h001;
        end
    end

    // Stand-in for the timer's own RC oscillator
    always @(posedge CLK) begin
        if (RESET || rc_div_q == RC_DIV - 5'h01) begin
            rc_div_q  <= 5'h00;
            rc_tick_q <= !RESET;
        end else begin
            rc_div_q  <= rc_div_q + 5'h01;
            rc_tick_q <= 1'b0;
        end
    end

    always @* begin
        state_d = state_q;
        cause_d = `RSS_CAUSE_NONE;
        case (state_q)
            S_HOLD: begin
                if (!hold_cond) begin
                    if (pend_powerup_timer_q && powerup_timer_on) begin
                        state_d = S_POWERUP_TIMER;                                  // [RULE_12]
                    end else if (pend_ost_q) begin
                        state_d = S_OST;                                   // [RULE_19]
                    end else begin
                        state_d = S_BIAS;
                    end
                end
            end
            S_POWERUP_TIMER, S_OST, S_BIAS, S_PINWAIT: begin
                if (por_cond) begin
                    state_d = S_HOLD;
                    cause_d = `RSS_CAUSE_POR;
                end else if (state_q == S_POWERUP_TIMER && !SUPPLY_ABOVE_BOR) begin
                    state_d = S_HOLD;                                      // [RULE_13]
                    cause_d = `RSS_CAUSE_BOR;
                end else if (OVERTEMP) begin
                    state_d = S_HOLD;
                    cause_d = `RSS_CAUSE_OT;
                end else if (state_q == S_POWERUP_TIMER) begin
                    if (powerup_timer_cnt_q >= POWERUP_TIMER_TICKS) begin
                        state_d = pend_ost_q ? S_OST : S_BIAS;
                    end
                end else if (state_q == S_OST || state_q == S_BIAS) begin
                    if (seq_done) begin
                        state_d = (state_q == S_OST) ? S_BIAS : S_PINWAIT; // [RULE_02]
                    end
                end else if (!pin_low_q) begin
                    state_d = S_RUN;                                       // [RULE_17] [RULE_18]
                end
            end
            S_RUN: begin
                if (por_cond) begin
                    state_d = S_HOLD;                                      // [RULE_03]
                    cause_d = `RSS_CAUSE_POR;
                end else if (bor_hit_q) begin
                    state_d = S_HOLD;
                    cause_d = `RSS_CAUSE_BOR;
                end else if (OVERTEMP) begin
                    state_d = S_HOLD;
                    cause_d = `RSS_CAUSE_OT;
                end else if (pin_low_q) begin
                    state_d = S_HOLD;
                    cause_d = `RSS_CAUSE_PIN;
                end else if (WATCHDOG_TIMEOUT) begin
                    state_d = S_HOLD;                                      // [RULE_20]
                    cause_d = `RSS_CAUSE_WDT;
                end else if (SLEEP_ENTER) begin
                    state_d = S_SLEEP;
                end
            end
            S_SLEEP: begin
                if (por_cond) begin
                    state_d = S_HOLD;
                    cause_d = `RSS_CAUSE_POR;
                end else if (OVERTEMP) begin
                    state_d = S_HOLD;
                    cause_d = `RSS_CAUSE_OT;
                end else if (pin_low_q) begin
                    state_d = S_HOLD;
                    cause_d = `RSS_CAUSE_PIN_SLP;
                end else if (WATCHDOG_TIMEOUT) begin
                    state_d = S_BIAS;                                      // [RULE_05]
                    cause_d = `RSS_CAUSE_WDT_WAKE;
                end else if (WAKE_EVENT) begin
                    state_d = S_BIAS;
                end
            end
            default: begin
                state_d = S_HOLD;
            end
        endcase
    end

    always @(posedge CLK) begin
        if (RESET) begin
            state_q      <= S_HOLD;
            cause_q      <= `RSS_CAUSE_POR;
            pend_powerup_timer_q  <= 1'b1;
            pend_ost_q   <= 1'b1;
            from_reset_q <= 1'b1;
        end else begin
            state_q <= state_d;
            if (cause_d != `RSS_CAUSE_NONE) begin
                cause_q <= cause_d;
            end
            if (cause_d == `RSS_CAUSE_POR || cause_d == `RSS_CAUSE_BOR) begin
                pend_powerup_timer_q <= 1'b1;                                       // [RULE_16]
            end else if (state_q == S_RUN) begin
                pend_powerup_timer_q <= 1'b0;
            end
            if (cause_d == `RSS_CAUSE_POR) begin
                pend_ost_q <= 1'b1;
            end else if (state_q == S_RUN) begin
                pend_ost_q <= 1'b0;
            end
            if (state_d == S_HOLD) begin
                from_reset_q <= 1'b1;
            end else if (state_d == S_RUN || state_d == S_SLEEP) begin
                from_reset_q <= 1'b0;
            end
        end
    end

    // Power-up timer runs only in its own state; any hold clears it
    always @(posedge CLK) begin
        if (RESET || state_q != S_POWERUP_TIMER || hold_cond) begin
            powerup_timer_cnt_q <= 17'h00000;                                       // [RULE_24]
        end else if (rc_tick_q && powerup_timer_cnt_q < POWERUP_TIMER_TICKS) begin
            powerup_timer_cnt_q <= powerup_timer_cnt_q + 17'h00001;
        end
    end

    always @(posedge CLK) begin
        if (RESET) begin
            seq_cnt_q <= 12'h000;
        end else if (state_d == S_OST && state_q != S_OST) begin
            seq_cnt_q <= {1'b0, OST_CYCLES};
        end else if (state_d == S_BIAS && state_q != S_BIAS) begin
            seq_cnt_q <= BIAS_CYC;
        end else if (seq_cnt_q != 12'h000) begin
            seq_cnt_q <= seq_cnt_q - 12'h001;
        end
    end

    // Hardware clear of the cause flags wins over a software set
    always @(posedge CLK) begin
        if (RESET) begin
            por_flag_n_q     <= `RSS_RST_POR_N;
            bor_flag_n_q     <= `RSS_RST_BOR_N;
            timeout_flag_q   <= `RSS_RST_TO;
            powerdown_flag_q <= `RSS_RST_PD;
        end else begin
            if (cause_d == `RSS_CAUSE_POR) begin
                por_flag_n_q <= 1'b0;                                      // [RULE_22]
            end else if (bus_wr && AVS_ADDRESS == `RSS_OFS_POWER_CTRL) begin
                por_flag_n_q <= AVS_WRITEDATA[`RSS_PC_POR_BIT];
            end
            if (cause_d == `RSS_CAUSE_BOR) begin
                bor_flag_n_q <= 1'b0;                                      // [RULE_23]
            end else if (bus_wr && AVS_ADDRESS == `RSS_OFS_POWER_CTRL) begin
                bor_flag_n_q <= AVS_WRITEDATA[`RSS_PC_BOR_BIT];
            end
            case (cause_d)
                `RSS_CAUSE_POR, `RSS_CAUSE_BOR: begin
                    timeout_flag_q   <= 1'b1;                              // [RULE_06]
                    powerdown_flag_q <= 1'b1;
                end
                `RSS_CAUSE_WDT: begin
                    timeout_flag_q <= 1'b0;
                end
                `RSS_CAUSE_WDT_WAKE: begin
                    timeout_flag_q   <= 1'b0;
                    powerdown_flag_q <= 1'b0;
                end
                `RSS_CAUSE_PIN_SLP: begin
                    timeout_flag_q   <= 1'b1;
                    powerdown_flag_q <= 1'b0;
                end
                default: begin
                    if (state_q == S_RUN && state_d == S_SLEEP) begin
                        timeout_flag_q   <= 1'b1;
                        powerdown_flag_q <= 1'b0;
                    end else if (state_q == S_RUN && WATCHDOG_CLEAR) begin
                        timeout_flag_q   <= 1'b1;
                        powerdown_flag_q <= 1'b1;
                    end
                end
            endcase
        end
    end

    // Trim lands after the settle window, never mid-window
    always @(posedge CLK) begin
        if (RESET) begin
            trim_target_q  <= `RSS_RST_TRIM;
            trim_applied_q <= `RSS_RST_TRIM;
            trim_cnt_q     <= 4'h0;
        end else if (bus_wr && AVS_ADDRESS == `RSS_OFS_OSC_TRIM) begin
            trim_target_q <= AVS_WRITEDATA[`RSS_TRIM_W-1:0];
            trim_cnt_q    <= TRIM_SETTLE;
        end else if (trim_cnt_q != 4'h0) begin
            trim_cnt_q <= trim_cnt_q - 4'h1;
            if (trim_cnt_q == 4'h1) begin
                trim_applied_q <= trim_target_q;                           // [RULE_01]
            end
        end
    end

    // Core-facing outputs, registered from the next state; pin pull-up registered from its enable
    always @(posedge CLK) begin
        if (RESET) begin
            reg_reset_q   <= 1'b1;
            fetch_en_q    <= 1'b0;
            wake_resume_q <= 1'b0;
            pullup_q      <= 1'b0;
        end else begin
            reg_reset_q   <= (state_d == S_HOLD) ||
                             (from_reset_q && state_d != S_RUN);           // [RULE_04]
            fetch_en_q    <= (state_d == S_RUN);
            wake_resume_q <= (state_q == S_BIAS) && (state_d == S_PINWAIT) && !from_reset_q;
            pullup_q      <= CFG_EXT_RESET_PIN_ENABLE;                     // [RULE_09]
        end
    end

    always @* begin
        rdata_d = 32'h00000000;
        case (AVS_ADDRESS)
            `RSS_OFS_POWER_CTRL: begin
                rdata_d[`RSS_PC_POR_BIT] = por_flag_n_q;
                rdata_d[`RSS_PC_BOR_BIT] = bor_flag_n_q;
            end
            `RSS_OFS_STATUS: begin
                rdata_d[`RSS_ST_TO_BIT] = timeout_flag_q;
                rdata_d[`RSS_ST_PD_BIT] = powerdown_flag_q;
                rdata_d[`RSS_ST_STATE_LSB+2:`RSS_ST_STATE_LSB] = state_q;
                rdata_d[`RSS_ST_SETTLE_BIT] = (trim_cnt_q != 4'h0);
            end
            `RSS_OFS_OSC_TRIM: begin
                rdata_d[`RSS_TRIM_W-1:0] = trim_target_q;
            end
            `RSS_OFS_CAUSE: begin
                rdata_d[2:0] = cause_q;
            end
            default: begin
                rdata_d = 32'h00000000;
            end
        endcase
    end

    // One wait cycle per access; unmapped reads give zero
    always @(posedge CLK) begin
        if (RESET) begin
            waitreq_q <= 1'b1;
            rdata_q   <= 32'h00000000;
        end else if ((AVS_READ || AVS_WRITE) && waitreq_q) begin
            waitreq_q <= 1'b0;
            rdata_q   <= AVS_READ ? rdata_d : 32'h00000000;
        end else begin
            waitreq_q <= 1'b1;
        end
    end

    assign EXT_RESET_PIN_OUT   = 1'b0;
    assign EXT_RESET_PIN_OE_N  = 1'b1;                                     // [RULE_08]
    assign EXT_RESET_PULLUP_EN = pullup_q;
    assign REG_RESET           = reg_reset_q;
    assign FETCH_ENABLE        = fetch_en_q;
    assign WAKE_RESUME         = wake_resume_q;
    assign TRIM_VALUE          = trim_applied_q;
    assign AVS_READDATA        = rdata_q;
    assign AVS_WAITREQUEST     = waitreq_q;

endmodule

/* pkg/rss_map.vh */
// Function
// RULE_01 - After a trim write, the applied trim settles within eight base clock periods.
// RULE_02 - After power-on or wake-up, wait about 10 us before the first fetch.
// RULE_03 - Reset comes from power-on, overtemperature, reset pin, watchdog and brown-out.
// RULE_04 - Most registers reset on power-on, pin, watchdog, brown-out; a few keep values.
// RULE_05 - A watchdog timeout during sleep wakes the core without any register reset.
// RULE_06 - Cause flags are set per cause: power-on, brown-out, watchdog, wake, pin.
// RULE_07 - The reset pin path ignores short low glitches; only a sustained low resets.
// RULE_08 - A watchdog reset stays internal and never drives the reset pin low.
// RULE_09 - Pin reset function is ignored when disabled; enabled means active low with pull-up.
// RULE_10 - With brown-out enabled, supply below threshold for 100 us raises brown-out reset.
// RULE_11 - After any reset, stay in reset until the supply is above the brown-out level.
// RULE_12 - An enabled power-up timer holds reset a further 64 ms after release.
// RULE_13 - Supply dropping during the power-up timer re-enters brown-out and restarts it.
// RULE_14 - With brown-out off or asleep, only the power-on detector asserts reset; with brown-out off the code still holds reset below the brown-out level.
// RULE_15 - The power-up timer enable bit is active low: 1 disables, 0 enables.
// RULE_16 - The power-up timer starts only after power-on, counts its own oscillator, holds reset; the code also starts it after a brown-out reset.
// RULE_17 - Execution starts after power-up timer, oscillator start-up timer and pin release.
// RULE_18 - Delays count from power-on; a pin held past them releases execution at once.
// RULE_19 - Timer disabled means no power-up delay; wake-up never applies the power-up delay.
// RULE_20 - A missed watchdog clear raises watchdog reset and updates timeout and powerdown flags; the code clears only the timeout flag.
// RULE_21 - The power-on detector holds the whole device in reset until supply is adequate.
// RULE_22 - Power-on flag, bit 1, cleared by power-on reset only; software writes it to 1.
// RULE_23 - Brown-out flag, bit 0, cleared by brown-out reset; software sets it back to 1.
// RULE_24 - Power-up timer counts oscillator ticks to a parameter; cleared by any reset condition.
`ifndef RSS_MAP_VH
`define RSS_MAP_VH

`define RSS_CLK_MHZ          20
`define RSS_T_BIAS_NS        10000
`define RSS_T_BOR_NS         100000
`define RSS_T_PIN_FILT_NS    2000
`define RSS_T_POWERUP_TIMER_US        64000
`define RSS_T_RC_TICK_NS     1000
`define RSS_TRIM_SETTLE_PER  4'h8
`define RSS_OST_CYCLES       1024

`define RSS_OFS_POWER_CTRL   8'h00
`define RSS_OFS_STATUS       8'h04
`define RSS_OFS_OSC_TRIM     8'h08
`define RSS_OFS_CAUSE        8'h0C

`define RSS_PC_BOR_BIT       0
`define RSS_PC_POR_BIT       1
`define RSS_ST_TO_BIT        0
`define RSS_ST_PD_BIT        1
`define RSS_ST_STATE_LSB     4
`define RSS_ST_SETTLE_BIT    8
`define RSS_TRIM_W           5

`define RSS_RST_POR_N        1'b0
`define RSS_RST_BOR_N        1'b1
`define RSS_RST_TO           1'b1
`define RSS_RST_PD           1'b1
`define RSS_RST_TRIM         5'h00

`define RSS_CAUSE_NONE       3'h0
`define RSS_CAUSE_POR        3'h1
`define RSS_CAUSE_BOR        3'h2
`define RSS_CAUSE_OT         3'h3
`define RSS_CAUSE_PIN        3'h4
`define RSS_CAUSE_WDT        3'h5
`define RSS_CAUSE_PIN_SLP    3'h6
`define RSS_CAUSE_WDT_WAKE   3'h7

`endif

/* tb/rss_sequencer_properties.sv */
`timescale 1ns/10ps
`include "rss_map.vh"
module rss_chk #(
    parameter [16:0] POWERUP_TIMER_TICKS = 17'd64000,
    parameter [10:0] OST_CYCLES = 11'd1024
) (
    input wire        CLK,
    input wire        RESET,
    input wire        SUPPLY_ABOVE_POR,
    input wire        SUPPLY_ABOVE_BOR,
    input wire        OVERTEMP,
    input wire        EXT_RESET_PIN_IN,
    input wire        EXT_RESET_PIN_OE_N,
    input wire        EXT_RESET_PULLUP_EN,
    input wire        WATCHDOG_TIMEOUT,
    input wire        SLEEP_ENTER,
    input wire        CFG_EXT_RESET_PIN_ENABLE,
    input wire        REG_RESET,
    input wire        FETCH_ENABLE,
    input wire        WAKE_RESUME,
    input wire [4:0]  TRIM_VALUE,
    input wire [7:0]  AVS_ADDRESS,
    input wire        AVS_WRITE,
    input wire [3:0]  AVS_BYTEENABLE,
    input wire [31:0] AVS_WRITEDATA,
    input wire        AVS_WAITREQUEST
);
    reg  [4:0] trim_q;
    wire       trim_wr = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0]
                         && AVS_ADDRESS == `RSS_OFS_OSC_TRIM;
    always @(posedge CLK) begin
        if (trim_wr) begin
            trim_q <= AVS_WRITEDATA[4:0];
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    // Every other cause that may drop execution on its own
    sequence s_quiet;
        SUPPLY_ABOVE_BOR && SUPPLY_ABOVE_POR && !OVERTEMP && !WATCHDOG_TIMEOUT && !SLEEP_ENTER;
    endsequence
    sequence s_pin_dip;
        FETCH_ENABLE && CFG_EXT_RESET_PIN_ENABLE && $fell(EXT_RESET_PIN_IN) ##0 s_quiet[*8];
    endsequence
    a_pin_filter: assert property (s_pin_dip |=> FETCH_ENABLE)
        else $error("short pin dip stopped execution");
    a_pin_undriven: assert property (WATCHDOG_TIMEOUT |-> EXT_RESET_PIN_OE_N[*4])
        else $error("reset pin driven after watchdog");
    a_pullup_follows: assert property (!$past(RESET) |->
        EXT_RESET_PULLUP_EN == $past(CFG_EXT_RESET_PIN_ENABLE))
        else $error("pull-up does not follow pin enable");
    a_por_holds: assert property (!SUPPLY_ABOVE_POR |-> ##[1:2] REG_RESET)
        else $error("low supply did not hold reset");
    a_overtemp_reset: assert property (OVERTEMP |-> ##[1:2] REG_RESET)
        else $error("overtemperature did not reset");
    a_wdt_stops: assert property (FETCH_ENABLE && WATCHDOG_TIMEOUT |-> ##[1:2] !FETCH_ENABLE)
        else $error("watchdog timeout left core running");
    a_wake_no_reset: assert property (WAKE_RESUME |-> !REG_RESET && !$past(REG_RESET))
        else $error("wake-up reset the registers");
    a_trim_settle: assert property (trim_wr |-> ##[1:9] TRIM_VALUE == trim_q)
        else $error("trim did not settle in time");
endmodule
bind rss_sequencer rss_chk #(.POWERUP_TIMER_TICKS(POWERUP_TIMER_TICKS), .OST_CYCLES(OST_CYCLES)) i_rss_chk (
    .CLK(CLK), .RESET(RESET), .SUPPLY_ABOVE_POR(SUPPLY_ABOVE_POR),
    .SUPPLY_ABOVE_BOR(SUPPLY_ABOVE_BOR), .OVERTEMP(OVERTEMP),
    .EXT_RESET_PIN_IN(EXT_RESET_PIN_IN), .EXT_RESET_PIN_OE_N(EXT_RESET_PIN_OE_N),
    .EXT_RESET_PULLUP_EN(EXT_RESET_PULLUP_EN), .WATCHDOG_TIMEOUT(WATCHDOG_TIMEOUT),
    .SLEEP_ENTER(SLEEP_ENTER), .CFG_EXT_RESET_PIN_ENABLE(CFG_EXT_RESET_PIN_ENABLE),
    .REG_RESET(REG_RESET), .FETCH_ENABLE(FETCH_ENABLE), .WAKE_RESUME(WAKE_RESUME),
    .TRIM_VALUE(TRIM_VALUE), .AVS_ADDRESS(AVS_ADDRESS), .AVS_WRITE(AVS_WRITE),
    .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST));

/* tb/rss_far.sv */
`timescale 1ns/10ps
module rss_far (
    input  wire CLK,
    input  wire hold_low,
    input  wire pullup_en,
    input  wire sag_bor,
    input  wire sag_por,
    output reg  pin,
    output wire above_por,
    output wire above_bor
);
    // A supply under the power-on level is under brown-out too
    assign above_por = !sag_por;
    assign above_bor = !(sag_por || sag_bor);
    initial pin = 1'b1;
    // Released pin floats to the pull-up, else wanders
    always @(posedge CLK) begin
        pin <= hold_low ? 1'b0 : (pullup_en ? 1'b1 : ~pin);
    end
endmodule

/* tb/tb.sv */
`timescale 1ns/10ps
`include "rss_map.vh"
module tb;
    reg CLK = 1'b0, RESET = 1'b1, OVERTEMP = 1'b0, WATCHDOG_TIMEOUT = 1'b0, WATCHDOG_CLEAR = 1'b0;
    reg SLEEP_ENTER = 1'b0, WAKE_EVENT = 1'b0, CFG_BROWNOUT_ENABLE = 1'b1;
    reg CFG_EXT_RESET_PIN_ENABLE = 1'b1, CFG_POWERUP_TIMER_DISABLE_N = 1'b0;
    reg AVS_READ = 1'b0, AVS_WRITE = 1'b0, hold_low = 1'b1, sag_bor = 1'b0, sag_por = 1'b0;
    reg [7:0] AVS_ADDRESS = 8'h00;
    reg [3:0] AVS_BYTEENABLE = 4'hF;
    reg [31:0] AVS_WRITEDATA = 32'h0, rd;
    wire SUPPLY_ABOVE_POR, SUPPLY_ABOVE_BOR, EXT_RESET_PIN_IN, EXT_RESET_PIN_OUT, AVS_WAITREQUEST;
    wire EXT_RESET_PIN_OE_N, EXT_RESET_PULLUP_EN, REG_RESET, FETCH_ENABLE, WAKE_RESUME;
    wire [4:0] TRIM_VALUE;
    wire [31:0] AVS_READDATA;
    int bad_count = 0, num_checks = 0, cyc = 0, n, g;
    int m_por, m_bor, m_to, m_pd, m_cause;
    rss_sequencer #(.POWERUP_TIMER_TICKS(17'h14), .OST_CYCLES(11'h4)) i_rss_sequencer (.*);
    rss_far i_rss_far (.CLK(CLK), .hold_low(hold_low), .pullup_en(EXT_RESET_PULLUP_EN),
        .sag_bor(sag_bor), .sag_por(sag_por), .pin(EXT_RESET_PIN_IN),
        .above_por(SUPPLY_ABOVE_POR), .above_bor(SUPPLY_ABOVE_BOR));
    task wrap_up;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input [31:0] seen, input [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task cy(input int k);
        repeat (k) @(posedge CLK);
    endtask
    task setm(input int p, b, t, d, c);
        m_por = p;
        m_bor = b;
        m_to = t;
        m_pd = d;
        m_cause = c;
    endtask
    // Request held until the edge that samples waitrequest low
    task bus(input wr, input [7:0] a, input [31:0] d);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_READ <= !wr;
        AVS_WRITE <= wr;
        do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0);
        rd = AVS_READDATA;
        AVS_READ <= 1'b0;
        AVS_WRITE <= 1'b0;
        @(posedge CLK);
    endtask
    task regs;
        bus(0, `RSS_OFS_POWER_CTRL, 0);
        chk(rd, {m_por[0], m_bor[0]});
        bus(0, `RSS_OFS_STATUS, 0);
        chk(rd[1:0], {m_pd[0], m_to[0]});
        bus(0, `RSS_OFS_CAUSE, 0);
        chk(rd[2:0], m_cause[2:0]);
    endtask
    task till(input v);
        n = 0;
        while (FETCH_ENABLE !== v) begin
            @(posedge CLK);
            n++;
        end
    endtask
    initial begin
        forever #25 CLK = ~CLK;
    end
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            wrap_up;
        end
    end
    initial begin
        g = $urandom(32'h78EA4FC0);
        cy(4);
        RESET <= 1'b0;
        setm(0, 1, 1, 1, 1);
        cy(1);
        regs;
        bus(1, 8'h10, 32'hFFFFFFFF);
        bus(0, 8'h10, 0);
        chk(rd, 0);
        cy(800);
        chk(FETCH_ENABLE, 0);
        hold_low <= 1'b0;
        till(1);
        chk(n <= 4, 1);
        bus(1, `RSS_OFS_POWER_CTRL, 32'h3);
        setm(1, 1, 1, 1, 1);
        regs;
        g = 1 + $urandom % 31;
        bus(1, `RSS_OFS_OSC_TRIM, g);
        bus(0, `RSS_OFS_OSC_TRIM, 0);
        chk(rd, g);
        cy(9);
        chk(TRIM_VALUE, g);
        hold_low <= 1'b1;
        cy(10 + $urandom % 20);
        hold_low <= 1'b0;
        cy(5);
        chk(FETCH_ENABLE, 1);
        hold_low <= 1'b1;
        cy(60);
        chk(FETCH_ENABLE, 0);
        hold_low <= 1'b0;
        setm(m_por, m_bor, m_to, m_pd, 4);
        till(1);
        regs;
        sag_bor <= 1'b1;
        cy(100);
        chk(FETCH_ENABLE, 1);
        cy(2000);
        chk(REG_RESET, 1);
        sag_bor <= 1'b0;
        cy(200);
        sag_bor <= 1'b1;
        cy(2);
        sag_bor <= 1'b0;
        setm(m_por, 0, 1, 1, 2);
        till(1);
        chk(n >= 580, 1);
        regs;
        WATCHDOG_TIMEOUT <= 1'b1;
        cy(1);
        WATCHDOG_TIMEOUT <= 1'b0;
        setm(m_por, m_bor, 0, m_pd, 5);
        till(0);
        till(1);
        regs;
        WATCHDOG_CLEAR <= 1'b1;
        cy(1);
        WATCHDOG_CLEAR <= 1'b0;
        setm(m_por, m_bor, 1, 1, 5);
        regs;
        SLEEP_ENTER <= 1'b1;
        cy(1);
        SLEEP_ENTER <= 1'b0;
        cy(3);
        chk(FETCH_ENABLE, 0);
        WATCHDOG_TIMEOUT <= 1'b1;
        cy(1);
        WATCHDOG_TIMEOUT <= 1'b0;
        while (WAKE_RESUME !== 1'b1) @(posedge CLK);
        chk(REG_RESET, 0);
        setm(m_por, m_bor, 0, 0, 7);
        till(1);
        regs;
        OVERTEMP <= 1'b1;
        cy(3);
        chk(REG_RESET, 1);
        OVERTEMP <= 1'b0;
        setm(m_por, m_bor, m_to, m_pd, 3);
        till(1);
        regs;
        CFG_BROWNOUT_ENABLE <= 1'b0;
        sag_bor <= 1'b1;
        cy(2100);
        chk(FETCH_ENABLE, 1);
        sag_bor <= 1'b0;
        CFG_BROWNOUT_ENABLE <= 1'b1;
        sag_por <= 1'b1;
        cy(3);
        chk(REG_RESET, 1);
        sag_por <= 1'b0;
        till(1);
        chk(n >= 584 && n <= 614, 1);
        bus(0, `RSS_OFS_POWER_CTRL, 0);
        chk(rd[1], 0);
        CFG_POWERUP_TIMER_DISABLE_N <= 1'b1;
        sag_por <= 1'b1;
        cy(3);
        sag_por <= 1'b0;
        till(1);
        chk(n >= 204 && n <= 214, 1);
        wrap_up;
    end
endmodule
